// ### design/psb_pkg.sv
// Purpose: Shared constants for the slot sideband board and card ends
// Assumes: One 125 MHz clock; slot pins modelled as in/out/enable triples
// Notes:   Output enables are active low (low while driving)
// Function
// - One request and grant per master, request released in reset
// - Arbiter ignores requests during reset
// - Master ignores its grant during reset
// - Parity error driven two clocks after data
// - Parity error one clock per bad phase
// - Parity error driven high one clock, then released
// - Report parity only as master or claimed target
// - System error for address, special cycle, fatal
// - System error low one clock, never high
// - Collector reports each sampled system error clock
// - Interrupts active low open drain level
// - Interrupt held until software clears request
// - Single function card uses pin A only
// - Riser upper slot AD22, pins rotate F G H E
// - Slot signals sampled on rising clock edge
package psb_pkg;
  localparam int unsigned PSB_MASTERS   = 4;
  localparam int unsigned PSB_INT_PINS  = 4;
  localparam int unsigned PSB_IRQ_LINES = 4;
  // Parity error reporting delay after the data phase, in clocks
  localparam int unsigned PSB_PERR_DELAY = 2;
  // Upper riser slot configuration select address line
  localparam int unsigned PSB_UPPER_IDSEL_BIT = 22;
  // Board lines E..H indices
  localparam logic [1:0] PSB_LINE_E = 2'h0;
  localparam logic [1:0] PSB_LINE_F = 2'h1;
  localparam logic [1:0] PSB_LINE_G = 2'h2;
  localparam logic [1:0] PSB_LINE_H = 2'h3;
  typedef enum logic [1:0] {
    PSB_PERR_IDLE  = 2'h0,
    PSB_PERR_LOW   = 2'h1,
    PSB_PERR_HIGH  = 2'h3
  } psb_perr_t;
endpackage

// ### design/psb_if.sv
`timescale 1ns/10ps
// Purpose: Slot sideband wires between the board and the card agents
// Assumes: Enables are active low; resolution is done by the testbench
// Notes:   Per master request/grant, shared parity, system error, interrupts
interface psb_if;
  import psb_pkg::*;
  logic [PSB_MASTERS-1:0]  req_n_out;
  logic [PSB_MASTERS-1:0]  req_n_oe_n;
  logic [PSB_MASTERS-1:0]  req_n_in;
  logic [PSB_MASTERS-1:0]  gnt_n_out;
  logic [PSB_MASTERS-1:0]  gnt_n_oe_n;
  logic [PSB_MASTERS-1:0]  gnt_n_in;
  logic                    perr_n_out;
  logic                    perr_n_oe_n;
  logic                    perr_n_in;
  logic                    serr_n_out;
  logic                    serr_n_oe_n;
  logic                    serr_n_in;
  logic [PSB_INT_PINS-1:0] int_n_out;
  logic [PSB_INT_PINS-1:0] int_n_oe_n;
  logic [PSB_INT_PINS-1:0] int_n_in;
  logic                    bus_rst;
  modport board (
    input  req_n_in, serr_n_in, int_n_in, perr_n_in,
    output gnt_n_out, gnt_n_oe_n, bus_rst
  );
  modport card (
    input  gnt_n_in, bus_rst,
    output req_n_out, req_n_oe_n, perr_n_out, perr_n_oe_n,
    output serr_n_out, serr_n_oe_n, int_n_out, int_n_oe_n
  );
endinterface

// ### design/psb_board.sv
`timescale 1ns/10ps
// Purpose: Board end: arbiter, system error collector, interrupt router
// Assumes: Slot pins synchronous to sys_clk_in; one master granted at a time
// Notes:   Round robin arbitration; riser mode is a static strap input
module psb_board #(
  parameter int unsigned MASTERS = psb_pkg::PSB_MASTERS
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           srst_in,
  input  wire logic                           bus_rst_req_in,
  input  wire logic                           riser_upper_in,
  psb_if.board                                slot,
  output logic                                serr_event_out,
  output logic [psb_pkg::PSB_IRQ_LINES-1:0]   irq_lines_n_out,
  output logic                                idsel_upper_out,
  output logic [MASTERS-1:0]                  gnt_active_out
);
  import psb_pkg::*;

  // ----------------------------------------------------------------
  // Bus reset and arbitration
  // ----------------------------------------------------------------
  logic                 bus_rst;
  logic                 next_bus_rst;
  logic [MASTERS-1:0]   gnt;
  logic [MASTERS-1:0]   next_gnt;
  logic [$clog2(MASTERS)-1:0] last;
  logic [$clog2(MASTERS)-1:0] next_last;
  logic                 gnt_oe_n;
  logic                 next_gnt_oe_n;
  localparam int unsigned LAST_W = $clog2(MASTERS);

  always_comb begin
    logic found;
    logic [$clog2(MASTERS)-1:0] idx;
    found         = 1'b0;
    idx           = '0;
    next_bus_rst  = srst_in | bus_rst_req_in;
    next_gnt      = '0;
    next_last     = last;
    next_gnt_oe_n = 1'b0;
    if (bus_rst) begin
      next_gnt_oe_n = 1'b1;
      next_last     = '0;
    end else if ((gnt != '0) && !slot.req_n_in[last]) begin
      next_gnt = gnt;                       // Keep owner while it requests
    end else begin
      for (int unsigned k = 1; k <= MASTERS; k++) begin
        idx = LAST_W'((last + k) % MASTERS);
        if (!found && !slot.req_n_in[idx]) begin
          found     = 1'b1;
          next_gnt  = MASTERS'(1) << idx;
          next_last = idx;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      bus_rst  <= 1'b1;
      gnt      <= '0;
      last     <= '0;
      gnt_oe_n <= 1'b1;
    end else begin
      bus_rst  <= next_bus_rst;
      gnt      <= next_gnt;
      last     <= next_last;
      gnt_oe_n <= next_gnt_oe_n;
    end
  end

  assign slot.bus_rst    = bus_rst;
  assign slot.gnt_n_out  = ~gnt;
  assign slot.gnt_n_oe_n = {MASTERS{gnt_oe_n}};

  // ----------------------------------------------------------------
  // System error collector and interrupt routing
  // ----------------------------------------------------------------
  logic                       next_serr_event;
  logic [PSB_IRQ_LINES-1:0]   next_irq;
  logic                       next_idsel_upper;

  always_comb begin
    // Every sampled low clock is one report; no edge detection on purpose
    next_serr_event  = !slot.serr_n_in;
    next_idsel_upper = riser_upper_in;
    if (riser_upper_in) begin
      next_irq[PSB_LINE_F] = slot.int_n_in[0];
      next_irq[PSB_LINE_G] = slot.int_n_in[1];
      next_irq[PSB_LINE_H] = slot.int_n_in[2];
      next_irq[PSB_LINE_E] = slot.int_n_in[3];
    end else begin
      next_irq[PSB_LINE_E] = slot.int_n_in[0];
      next_irq[PSB_LINE_F] = slot.int_n_in[1];
      next_irq[PSB_LINE_G] = slot.int_n_in[2];
      next_irq[PSB_LINE_H] = slot.int_n_in[3];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      serr_event_out  <= 1'b0;
      irq_lines_n_out <= '1;
      idsel_upper_out <= 1'b0;
      gnt_active_out  <= '0;
    end else begin
      serr_event_out  <= next_serr_event;
      irq_lines_n_out <= next_irq;
      idsel_upper_out <= next_idsel_upper;
      gnt_active_out  <= next_gnt;
    end
  end
endmodule // psb_board

// ### design/psb_card.sv
`timescale 1ns/10ps
// Purpose: Card end: bus request, parity/system error and interrupt drive
// Assumes: User side supplies one-cycle error and data phase indications
// Notes:   Master index selects which request/grant pair this card owns
module psb_card #(
  parameter int unsigned MASTER_IDX = 0,
  parameter bit          MULTI_FUNC = 1'b0
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          srst_in,
  psb_if.card                                slot,
  input  wire logic                          want_bus_in,
  input  wire logic                          err_enable_in,
  input  wire logic                          data_phase_in,
  input  wire logic                          parity_bad_in,
  input  wire logic                          is_master_in,
  input  wire logic                          devsel_claimed_in,
  input  wire logic                          special_cycle_in,
  input  wire logic                          addr_parity_bad_in,
  input  wire logic                          fatal_err_in,
  input  wire logic [psb_pkg::PSB_INT_PINS-1:0] int_req_in,
  output logic                               granted_out
);
  import psb_pkg::*;

  // ----------------------------------------------------------------
  // Request and parity error state
  // ----------------------------------------------------------------
  logic                       req_on;
  logic                       next_req_on;
  logic                       granted;
  logic                       next_granted;
  // State register is the last delay stage, so the pipe is one shorter
  logic [PSB_PERR_DELAY-2:0]  perr_pipe;
  logic [PSB_PERR_DELAY-2:0]  next_perr_pipe;
  psb_perr_t                  perr_st;
  psb_perr_t                  next_perr_st;
  logic                       serr_on;
  logic                       next_serr_on;
  logic [PSB_INT_PINS-1:0]    int_on;
  logic [PSB_INT_PINS-1:0]    next_int_on;
  logic                       perr_detect;
  logic                       serr_detect;

  // Special cycle data errors go to system error, never parity error
  assign perr_detect = err_enable_in && data_phase_in && parity_bad_in && !special_cycle_in
                       && (is_master_in || devsel_claimed_in);
  assign serr_detect = err_enable_in && (addr_parity_bad_in || fatal_err_in
                       || (data_phase_in && parity_bad_in && special_cycle_in));

  always_comb begin
    next_req_on    = !slot.bus_rst && want_bus_in;
    next_granted   = !slot.bus_rst && !slot.gnt_n_in[MASTER_IDX];
    next_perr_pipe = (PSB_PERR_DELAY-1)'({perr_pipe, perr_detect});
    next_serr_on   = serr_detect && !slot.bus_rst;
    next_perr_st   = perr_st;
    unique case (perr_st)
      PSB_PERR_IDLE: if (perr_pipe[PSB_PERR_DELAY-2]) next_perr_st = PSB_PERR_LOW;
      PSB_PERR_LOW: begin
        // Stays low while consecutive phases keep failing
        if (!perr_pipe[PSB_PERR_DELAY-2]) next_perr_st = PSB_PERR_HIGH;
      end
      PSB_PERR_HIGH: begin
        if (perr_pipe[PSB_PERR_DELAY-2]) next_perr_st = PSB_PERR_LOW;
        else next_perr_st = PSB_PERR_IDLE;
      end
      default: next_perr_st = PSB_PERR_IDLE;
    endcase
    if (slot.bus_rst) begin
      next_perr_st   = PSB_PERR_IDLE;
      next_perr_pipe = '0;
    end
    // Level held by user until software clears the source
    next_int_on = int_req_in;
    if (!MULTI_FUNC) next_int_on = {{(PSB_INT_PINS-1){1'b0}}, int_req_in[0]};
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      req_on      <= 1'b0;
      granted     <= 1'b0;
      perr_pipe   <= '0;
      perr_st     <= PSB_PERR_IDLE;
      serr_on     <= 1'b0;
      int_on      <= '0;
      granted_out <= 1'b0;
    end else begin
      req_on      <= next_req_on;
      granted     <= next_granted;
      perr_pipe   <= next_perr_pipe;
      perr_st     <= next_perr_st;
      serr_on     <= next_serr_on;
      int_on      <= next_int_on;
      granted_out <= next_granted;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < PSB_MASTERS; m++) begin : g_req
      assign slot.req_n_out[m]  = !(req_on && (m == MASTER_IDX));
      assign slot.req_n_oe_n[m] = !((m == MASTER_IDX) && !slot.bus_rst);
    end
  endgenerate

  assign slot.perr_n_out  = (perr_st != PSB_PERR_LOW);
  assign slot.perr_n_oe_n = (perr_st == PSB_PERR_IDLE);
  assign slot.serr_n_out  = 1'b0;
  assign slot.serr_n_oe_n = !serr_on;
  assign slot.int_n_out   = '0;
  assign slot.int_n_oe_n  = ~int_on;
endmodule // psb_card

// ### verif/psb_props.sv
`timescale 1ns/10ps
// Purpose: Wire checks on the slot sideband between board and card
// Assumes: One clock, sync reset; enables low while driving
// Notes:   Sees interface signals only, not the user sides
module psb_props
  import psb_pkg::*;
#(
  parameter bit MULTI_FUNC = 1'b0
) (
  input wire logic                    sys_clk_in,
  input wire logic                    srst_in,
  input wire logic [PSB_MASTERS-1:0]  req_n_in,
  input wire logic [PSB_MASTERS-1:0]  req_n_oe_n,
  input wire logic [PSB_MASTERS-1:0]  gnt_n_out,
  input wire logic [PSB_MASTERS-1:0]  gnt_n_oe_n,
  input wire logic                    perr_n_out,
  input wire logic                    perr_n_oe_n,
  input wire logic                    serr_n_out,
  input wire logic                    serr_n_oe_n,
  input wire logic [PSB_INT_PINS-1:0] int_n_out,
  input wire logic [PSB_INT_PINS-1:0] int_n_oe_n,
  input wire logic                    bus_rst
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [PSB_MASTERS-1:0] gnt_on;
  assign gnt_on = ~gnt_n_out & ~gnt_n_oe_n;
  a_gnt_one_hot: assert property ($onehot0(gnt_on)) else $error("two grants at once");
  a_rst_gnt_off: assert property (bus_rst && $past(bus_rst) |-> &gnt_n_oe_n) else $error("grant driven in bus reset");
  a_gnt_needs_req: assert property (!bus_rst |-> !(|(gnt_on & $past(req_n_in)))) else $error("grant without request");
  a_rst_req_float: assert property (bus_rst && $past(bus_rst) |-> &req_n_oe_n) else $error("request driven in reset");
  a_rst_err_float: assert property (bus_rst && $past(bus_rst) |-> perr_n_oe_n && serr_n_oe_n) else $error("error pin driven");
  a_serr_low_only: assert property (!serr_n_oe_n |-> !serr_n_out) else $error("system error driven high");
  a_perr_high_one: assert property (!perr_n_oe_n && perr_n_out && !$past(perr_n_oe_n) && !$past(perr_n_out)
    |=> perr_n_oe_n) else $error("parity high not one clock");
  a_perr_release: assert property ($rose(perr_n_oe_n) |-> $past(perr_n_out)) else $error("parity released low");
  a_int_low_only: assert property (!(|(int_n_out & ~int_n_oe_n))) else $error("interrupt driven high");
  a_int_pin_a: assert property (MULTI_FUNC || &int_n_oe_n[PSB_INT_PINS-1:1]) else $error("pin B to D used");
  c_grant: cover property (|gnt_on);
  c_perr: cover property (!perr_n_oe_n && !perr_n_out);
  c_serr: cover property (!serr_n_oe_n);
  c_int: cover property (!(&int_n_oe_n));
endmodule // psb_props

// ### verif/test_pci_arb_error_intr_signals.sv
`timescale 1ns/10ps
// Purpose: Board and card ends back to back, driven from the user sides
// Assumes: Pull-ups on every slot wire; masters 1..3 are driven here
// Notes:   Masters 1..3 pull requests low in reset on purpose
module test_pci_arb_error_intr_signals;
  import psb_pkg::*;
  logic       srst_in = 1'b1, want_bus_in = 1'b1, is_master_in = 1'b1, sys_clk_in = 1'b0;
  logic       riser_upper_in = 1'b0, err_enable_in = 1'b0, data_phase_in = 1'b0, parity_bad_in = 1'b0;
  logic       bus_rst_req_in = 1'b0;
  logic       devsel_claimed_in = 1'b0, special_cycle_in = 1'b0, fatal_err_in = 1'b0;
  logic       serr_event_out, idsel_upper_out, granted_out;
  logic [3:0] irq_lines_n_out, gnt_active_out, int_req_in = 4'h0, ext_req_n = 4'h1;
  int         error_cnt = 0, comparisons = 0, cycles = 0;
  psb_if slot();
  // Wire resolution: a released line reads high
  assign slot.req_n_in = (slot.req_n_out | slot.req_n_oe_n) & ext_req_n;
  assign slot.gnt_n_in = slot.gnt_n_out | slot.gnt_n_oe_n;
  assign slot.perr_n_in = slot.perr_n_out | slot.perr_n_oe_n;
  assign slot.serr_n_in = slot.serr_n_out | slot.serr_n_oe_n;
  assign slot.int_n_in = slot.int_n_out | slot.int_n_oe_n;
  psb_board i_psb_board (.sys_clk_in, .srst_in, .bus_rst_req_in, .riser_upper_in, .slot(slot),
    .serr_event_out, .irq_lines_n_out, .idsel_upper_out, .gnt_active_out);
  psb_card i_psb_card (.sys_clk_in, .srst_in, .slot(slot), .want_bus_in, .err_enable_in, .data_phase_in,
    .parity_bad_in, .is_master_in, .devsel_claimed_in, .special_cycle_in, .addr_parity_bad_in(1'b0),
    .fatal_err_in, .int_req_in, .granted_out);
  psb_props #(.MULTI_FUNC(1'b0)) i_psb_props (.sys_clk_in, .srst_in, .req_n_in(slot.req_n_in),
    .req_n_oe_n(slot.req_n_oe_n), .gnt_n_out(slot.gnt_n_out), .gnt_n_oe_n(slot.gnt_n_oe_n),
    .perr_n_out(slot.perr_n_out), .perr_n_oe_n(slot.perr_n_oe_n), .serr_n_out(slot.serr_n_out),
    .serr_n_oe_n(slot.serr_n_oe_n), .int_n_out(slot.int_n_out), .int_n_oe_n(slot.int_n_oe_n),
    .bus_rst(slot.bus_rst));
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic summarize;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One error event of len clocks, then a trace of the error wires
  task automatic bad_phase(input logic en, input logic sp, input logic fe, input int len,
                           input logic [6:0] e_perr, input logic [6:0] e_oe, input logic [6:0] e_serr);
    logic [6:0] t_perr, t_oe, t_serr, t_evt;
    err_enable_in = en;
    special_cycle_in = sp;
    fatal_err_in = fe;
    data_phase_in = !fe;
    parity_bad_in = !fe;
    for (int k = 0; k < 7; k++) begin
      step(1);
      if (k == len - 1) begin
        data_phase_in = 1'b0;
        parity_bad_in = 1'b0;
        fatal_err_in = 1'b0;
      end
      t_perr[k] = slot.perr_n_in;
      t_oe[k] = slot.perr_n_oe_n;
      t_serr[k] = slot.serr_n_in;
      t_evt[k] = serr_event_out;
    end
    chk(t_perr, e_perr);
    chk(t_oe, e_oe);
    chk(t_serr, e_serr);
    chk(t_evt, {~e_serr[5:0], 1'b0});
  endtask
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      summarize();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    step(5);
    chk(gnt_active_out, 4'h0);
    chk(slot.req_n_oe_n[0], 1'b1);
    chk(granted_out, 1'b0);
    srst_in = 1'b0;
    want_bus_in = 1'b0;
    ext_req_n = 4'hB;
    for (int k = 0; k < 8 && gnt_active_out !== 4'h4; k++) step(1);
    chk(gnt_active_out, 4'h4);
    want_bus_in = 1'b1;
    step(3);
    chk(gnt_active_out, 4'h4);
    ext_req_n = 4'hF;
    for (int k = 0; k < 8 && gnt_active_out !== 4'h1; k++) step(1);
    step(2);
    chk(gnt_active_out, 4'h1);
    chk(granted_out, 1'b1);
    want_bus_in = 1'b0;
    step(4);
    chk(gnt_active_out, 4'h0);
    bad_phase(1'b1, 1'b0, 1'b0, 1, 7'h7D, 7'h79, 7'h7F);
    bad_phase(1'b1, 1'b0, 1'b0, 2, 7'h79, 7'h71, 7'h7F);
    bad_phase(1'b0, 1'b0, 1'b0, 1, 7'h7F, 7'h7F, 7'h7F);
    bad_phase(1'b1, 1'b1, 1'b0, 1, 7'h7F, 7'h7F, 7'h7E);
    bad_phase(1'b1, 1'b0, 1'b1, 1, 7'h7F, 7'h7F, 7'h7E);
    is_master_in = 1'b0;
    bad_phase(1'b1, 1'b0, 1'b0, 1, 7'h7F, 7'h7F, 7'h7F);
    devsel_claimed_in = 1'b1;
    bad_phase(1'b1, 1'b0, 1'b0, 1, 7'h7D, 7'h79, 7'h7F);
    int_req_in = 4'h1;
    step(3);
    chk(irq_lines_n_out, 4'hE);
    riser_upper_in = 1'b1;
    step(3);
    chk(irq_lines_n_out, 4'hD);
    chk(idsel_upper_out, 1'b1);
    int_req_in = 4'h3;
    step(3);
    chk(irq_lines_n_out, 4'hD);
    int_req_in = 4'h0;
    step(3);
    chk(irq_lines_n_out, 4'hF);
    // Bus reset in mid-run while master 0 owns the bus
    want_bus_in = 1'b1;
    step(3);
    chk(gnt_active_out, 4'h1);
    bus_rst_req_in = 1'b1;
    step(2);
    chk(gnt_active_out, 4'h0);
    chk(granted_out, 1'b0);
    chk(slot.req_n_oe_n[0], 1'b1);
    bus_rst_req_in = 1'b0;
    step(4);
    chk(gnt_active_out, 4'h1);
    chk(granted_out, 1'b1);
    summarize();
  end
endmodule // test_pci_arb_error_intr_signals
